// [logic/ppc_pkg.sv]
package ppc_pkg;

  // ==========================================================================
  // Register map and field layout.
  // ==========================================================================
  localparam logic [3:0]  ADDR_IO_CONTROL = 4'h0;
  localparam logic [3:0]  ADDR_UNLOCK     = 4'h1;
  localparam logic [3:0]  ADDR_STATUS     = 4'h2;
  localparam logic [3:0]  ADDR_HANDLING   = 4'h3;

  localparam int BIT_HIGH_OWN   = 15;
  localparam int BIT_LOW_OWN    = 14;
  localparam int BIT_HIGH_POL   = 13;
  localparam int BIT_LOW_POL    = 12;
  localparam int BIT_MODE_HI    = 11;
  localparam int BIT_MODE_LO    = 10;
  localparam int BIT_HIGH_OVR   = 9;
  localparam int BIT_LOW_OVR    = 8;
  localparam int BIT_OVR_DAT_H  = 7;
  localparam int BIT_OVR_DAT_L  = 6;
  localparam int BIT_FLT_DAT_H  = 5;
  localparam int BIT_FLT_DAT_L  = 4;
  localparam int BIT_CL_DAT_H   = 3;
  localparam int BIT_CL_DAT_L   = 2;

  localparam logic [15:0] IO_CONTROL_RESET = 16'hC000;
  localparam logic [15:0] IO_CONTROL_MASK  = 16'hFFFC;

  // Two-word key written to the unlock register, in this order.
  localparam logic [15:0] UNLOCK_KEY_A = 16'h0055;
  localparam logic [15:0] UNLOCK_KEY_B = 16'h00AA;

  // Handling register: bit 0 fault handling, bit 1 current-limit handling.
  localparam int BIT_FLT_HANDLING = 0;
  localparam int BIT_CL_HANDLING  = 1;

  typedef enum logic [1:0] {
    MODE_COMPLEMENTARY = 2'h0,
    MODE_REDUNDANT     = 2'h1,
    MODE_PUSH_PULL     = 2'h2,
    MODE_RESERVED      = 2'h3
  } ppc_mode_type;

  typedef enum logic [1:0] {
    UNL_LOCKED,
    UNL_KEY_SEEN,
    UNL_OPEN
  } ppc_unlock_type;

endpackage

// [logic/ppc_unlock.sv]
// ============================================================================
// Unlock sequencer: opens the control register for exactly one write.
// ============================================================================
module ppc_unlock (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        key_wr_i,
  input  wire logic [15:0] key_data_i,
  input  wire logic        ctrl_wr_i,
  output logic             open_o
);

  typedef struct packed {
    ppc_pkg::ppc_unlock_type st;
  } ppc_ul_state_type;

  ppc_ul_state_type state;
  ppc_ul_state_type next_state;

  // Any wrong key, or any control write, drops back to locked.
  always_comb begin
    next_state = state;
    if (ctrl_wr_i) begin
      next_state.st = ppc_pkg::UNL_LOCKED;
    end else if (key_wr_i) begin
      case (state.st)
        ppc_pkg::UNL_LOCKED: begin
          next_state.st = (key_data_i == ppc_pkg::UNLOCK_KEY_A) ? ppc_pkg::UNL_KEY_SEEN : ppc_pkg::UNL_LOCKED;
        end
        ppc_pkg::UNL_KEY_SEEN: begin
          next_state.st = (key_data_i == ppc_pkg::UNLOCK_KEY_B) ? ppc_pkg::UNL_OPEN : ppc_pkg::UNL_LOCKED;
        end
        default: begin
          next_state.st = ppc_pkg::UNL_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state.st <= ppc_pkg::UNL_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  assign open_o = (state.st == ppc_pkg::UNL_OPEN);

endmodule

// [logic/ppc_sync.sv]
// ============================================================================
// Two-flop synchroniser for a group of pin-level inputs.
// ============================================================================
module ppc_sync (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] d_i,
  output logic      [3:0] q_o
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } ppc_sync_state_type;

  ppc_sync_state_type state;
  ppc_sync_state_type next_state;

  // The first stage feeds only the second stage.
  always_comb begin
    next_state.s1 = d_i;
    next_state.s2 = state.s1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign q_o = state.s2;

endmodule

// [logic/ppc_pin_control.sv]
module ppc_pin_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        lock_config_i,
  input  wire logic        timebase_enable_i,
  input  wire logic        gen_high_i,
  input  wire logic        gen_low_i,
  input  wire logic        push_pull_phase_i,
  input  wire logic        fault_i,
  input  wire logic        current_limit_i,
  input  wire logic        gpio_high_i,
  input  wire logic        gpio_low_i,
  output logic             high_output_pin_o,
  output logic             low_output_pin_o,
  output logic             write_refused_o
);

  // ==========================================================================
  // State.
  // ==========================================================================
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0]  handling;
    logic [15:0] rdata;
    logic        refused;
    logic        high_pin;
    logic        low_pin;
    logic        mode_changed_running;
  } ppc_state_type;

  ppc_state_type state;
  ppc_state_type next_state;

  logic [3:0] pins_sync;
  logic       unlock_open;
  logic       wr_ctrl;
  logic       wr_key;
  logic       ctrl_accept;
  logic       fault_s;
  logic       climit_s;
  logic       gen_hi_s;
  logic       gen_lo_s;

  // ==========================================================================
  // Pin inputs and unlock.
  // ==========================================================================
  // Fault and limit come from comparators or pins, so they are synchronised.
  ppc_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({fault_i, current_limit_i, gpio_high_i, gpio_low_i}),
    .q_o   (pins_sync)
  );

  assign fault_s  = pins_sync[3];
  assign climit_s = pins_sync[2];
  assign gen_hi_s = gen_high_i;
  assign gen_lo_s = gen_low_i;

  // Decode of the register port.
  assign wr_ctrl = wr_i && (addr_i == ppc_pkg::ADDR_IO_CONTROL);
  assign wr_key  = wr_i && (addr_i == ppc_pkg::ADDR_UNLOCK);

  ppc_unlock u_unlock (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .key_wr_i   (wr_key),
    .key_data_i (wdata_i),
    .ctrl_wr_i  (wr_ctrl),
    .open_o     (unlock_open)
  );

  // A locked device takes a control write only once the key pair has opened the sequencer.
  assign ctrl_accept = wr_ctrl && (!lock_config_i || unlock_open);

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Fault first, then current limit, then override, then the generator.
  function automatic logic ppc_select(input logic flt_on, input logic flt_d,
                                      input logic cl_on, input logic cl_d,
                                      input logic ovr_on, input logic ovr_d,
                                      input logic gen);
    logic v;
    if (flt_on) begin
      v = flt_d;
    end else if (cl_on) begin
      v = cl_d;
    end else if (ovr_on) begin
      v = ovr_d;
    end else begin
      v = gen;
    end
    return v;
  endfunction

  // Active-low polarity inverts the chosen level on its way to the pin.
  function automatic logic ppc_polarity(input logic level, input logic pol);
    return level ^ pol;
  endfunction

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    logic         flt_on;
    logic         cl_on;
    logic         gen_h;
    logic         gen_l;
    logic         sel_h;
    logic         sel_l;
    ppc_pkg::ppc_mode_type mode;
    flt_on = 1'b0;
    cl_on  = 1'b0;
    gen_h  = 1'b0;
    gen_l  = 1'b0;
    sel_h  = 1'b0;
    sel_l  = 1'b0;
    mode   = ppc_pkg::ppc_mode_type'(state.ctrl[ppc_pkg::BIT_MODE_HI:ppc_pkg::BIT_MODE_LO]);
    next_state = state;

    // Register writes; the two low bits are not held here and read zero.
    next_state.refused = wr_ctrl && !ctrl_accept;
    if (ctrl_accept) begin
      next_state.ctrl = wdata_i & ppc_pkg::IO_CONTROL_MASK;
      // A mode change while the timebase runs is flagged, not blocked.
      next_state.mode_changed_running = state.mode_changed_running | (timebase_enable_i &&
        (wdata_i[ppc_pkg::BIT_MODE_HI:ppc_pkg::BIT_MODE_LO] !=
         state.ctrl[ppc_pkg::BIT_MODE_HI:ppc_pkg::BIT_MODE_LO]));
    end
    if (wr_i && (addr_i == ppc_pkg::ADDR_HANDLING)) begin
      next_state.handling = wdata_i[1:0];
    end

    // Read data stands only in the cycle after the strobe.
    next_state.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ppc_pkg::ADDR_IO_CONTROL: next_state.rdata = state.ctrl;
        ppc_pkg::ADDR_HANDLING:   next_state.rdata = {14'h0000, state.handling};
        ppc_pkg::ADDR_STATUS:     next_state.rdata = {11'h000, state.mode_changed_running, unlock_open,
                                                      climit_s, fault_s, lock_config_i};
        default:                  next_state.rdata = 16'h0000;
      endcase
    end

    // Pin-pair mode shapes the generator pair before overrides apply.
    case (mode)
      ppc_pkg::MODE_COMPLEMENTARY: begin
        gen_h = gen_hi_s;
        gen_l = !gen_hi_s;
      end
      ppc_pkg::MODE_REDUNDANT: begin
        gen_h = gen_hi_s;
        gen_l = gen_hi_s;
      end
      ppc_pkg::MODE_PUSH_PULL: begin
        gen_h = gen_hi_s && push_pull_phase_i;
        gen_l = gen_hi_s && !push_pull_phase_i;
      end
      default: begin
        // Reserved code: each output follows its own generator line.
        gen_h = gen_hi_s;
        gen_l = gen_lo_s;
      end
    endcase

    flt_on = fault_s && state.handling[ppc_pkg::BIT_FLT_HANDLING];
    cl_on  = climit_s && state.handling[ppc_pkg::BIT_CL_HANDLING];

    sel_h = ppc_select(flt_on, state.ctrl[ppc_pkg::BIT_FLT_DAT_H],
                       cl_on, state.ctrl[ppc_pkg::BIT_CL_DAT_H],
                       state.ctrl[ppc_pkg::BIT_HIGH_OVR], state.ctrl[ppc_pkg::BIT_OVR_DAT_H],
                       gen_h);
    sel_l = ppc_select(flt_on, state.ctrl[ppc_pkg::BIT_FLT_DAT_L],
                       cl_on, state.ctrl[ppc_pkg::BIT_CL_DAT_L],
                       state.ctrl[ppc_pkg::BIT_LOW_OVR], state.ctrl[ppc_pkg::BIT_OVR_DAT_L],
                       gen_l);

    // Ownership: GPIO levels pass straight through when the port owns a pin.
    next_state.high_pin = state.ctrl[ppc_pkg::BIT_HIGH_OWN]
      ? ppc_polarity(sel_h, state.ctrl[ppc_pkg::BIT_HIGH_POL]) : pins_sync[1];
    next_state.low_pin = state.ctrl[ppc_pkg::BIT_LOW_OWN]
      ? ppc_polarity(sel_l, state.ctrl[ppc_pkg::BIT_LOW_POL]) : pins_sync[0];
  end

  // ==========================================================================
  // Registers.
  // ==========================================================================
  // Pins reset to low; with the reset control word the low pin then follows the inverted generator.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state.ctrl                 <= ppc_pkg::IO_CONTROL_RESET;
      state.handling             <= 2'h0;
      state.rdata                <= 16'h0000;
      state.refused              <= 1'b0;
      state.high_pin             <= 1'b0;
      state.low_pin              <= 1'b0;
      state.mode_changed_running <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o           = state.rdata;
  assign high_output_pin_o = state.high_pin;
  assign low_output_pin_o  = state.low_pin;
  assign write_refused_o   = state.refused;

  // ==========================================================================
  // Checks.
  // ==========================================================================
  // The two keys on consecutive writes to the unlock register.
  sequence s_key_pair;
    wr_key && wdata_i == ppc_pkg::UNLOCK_KEY_A ##1 wr_key && wdata_i == ppc_pkg::UNLOCK_KEY_B;
  endsequence

  chk_locked_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && lock_config_i && !unlock_open |=> $stable(state.ctrl) && write_refused_o)
    else $error("locked control write changed the register");

  chk_unlock_then_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_key_pair ##1 (wr_ctrl && !rd_i) |=> state.ctrl == $past(wdata_i & ppc_pkg::IO_CONTROL_MASK))
    else $error("write after unlock was not taken");

  chk_fault_high_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_s && state.handling[0] && state.ctrl[15] |=>
      high_output_pin_o == ($past(state.ctrl[5]) ^ $past(state.ctrl[13])))
    else $error("fault data not on high pin");

  chk_limit_low_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    climit_s && !(fault_s && state.handling[0]) && state.handling[1] && state.ctrl[14] |=>
      low_output_pin_o == ($past(state.ctrl[2]) ^ $past(state.ctrl[12])))
    else $error("limit data not on low pin");

  chk_override_high: assert property (@(posedge clk_i) disable iff (rst_i)
    !(fault_s && state.handling[0]) && !(climit_s && state.handling[1]) && state.ctrl[15] && state.ctrl[9] |=>
      high_output_pin_o == ($past(state.ctrl[7]) ^ $past(state.ctrl[13])))
    else $error("override data not on high pin");

  chk_override_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !(fault_s && state.handling[0]) && !(climit_s && state.handling[1]) && state.ctrl[14] && state.ctrl[8] |=>
      low_output_pin_o == ($past(state.ctrl[6]) ^ $past(state.ctrl[12])))
    else $error("override data not on low pin");

  chk_gpio_high: assert property (@(posedge clk_i) disable iff (rst_i)
    !state.ctrl[15] |=> high_output_pin_o == $past(pins_sync[1]))
    else $error("gpio not driving high pin");

  chk_gpio_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !state.ctrl[14] |=> low_output_pin_o == $past(pins_sync[0]))
    else $error("gpio not driving low pin");

  chk_complementary: assert property (@(posedge clk_i) disable iff (rst_i)
    state.ctrl[15:8] == 8'hC0 && !(fault_s && state.handling[0]) && !(climit_s && state.handling[1])
      |=> high_output_pin_o != low_output_pin_o)
    else $error("complementary pair not opposite");

  chk_redundant_pol: assert property (@(posedge clk_i) disable iff (rst_i)
    state.ctrl[15:8] == 8'hE4 && !(fault_s && state.handling[0]) && !(climit_s && state.handling[1])
      |=> high_output_pin_o != low_output_pin_o)
    else $error("high polarity not inverting");

  // Reset leaves the control word at its reset value and both pins low.
  chk_reset_value: assert property (@(posedge clk_i)
    $fell(rst_i) |-> state.ctrl == ppc_pkg::IO_CONTROL_RESET && !high_output_pin_o && !low_output_pin_o)
    else $error("reset state wrong");

  // A refusal pulse only ever follows a control write refused by the lock.
  chk_refusal_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    write_refused_o |-> $past(wr_ctrl && lock_config_i && !unlock_open))
    else $error("refusal pulse without a refused write");

  // The register opens only on the second key, never on any other write.
  chk_unlock_opens: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(unlock_open) |-> $past(wr_key && wdata_i == ppc_pkg::UNLOCK_KEY_B))
    else $error("register opened without the second key");

  // Status reports the lock input and the open state seen at the read.
  chk_status_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == ppc_pkg::ADDR_STATUS |=>
      rdata_o[0] == $past(lock_config_i) && rdata_o[3] == $past(unlock_open))
    else $error("status does not report the lock");

  // Limit data win over the generator on the high pin as well.
  chk_limit_high_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    climit_s && !(fault_s && state.handling[0]) && state.handling[1] && state.ctrl[15] |=>
      high_output_pin_o == ($past(state.ctrl[3]) ^ $past(state.ctrl[13])))
    else $error("limit data not on high pin");

  // A handled fault held on its pin for three edges has passed both sync
  // stages, so from the next edge on the low pin must carry the fault data.
  sequence s_fault_pin_held;
    (fault_i && state.handling[ppc_pkg::BIT_FLT_HANDLING]) [*3];
  endsequence

  chk_fault_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fault_pin_held ##0 state.ctrl[ppc_pkg::BIT_LOW_OWN] |=>
      low_output_pin_o == ($past(state.ctrl[4]) ^ $past(state.ctrl[12])))
    else $error("fault data late on low pin");

  // Fault data win over current-limit data when both are handled.
  chk_fault_over_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_s && climit_s && state.handling == 2'h3 && state.ctrl[14] |=>
      low_output_pin_o == ($past(state.ctrl[4]) ^ $past(state.ctrl[12])))
    else $error("limit data beat fault data");

  // Push-pull steers the generator to one pin at a time, never to both.
  chk_push_pull_split: assert property (@(posedge clk_i) disable iff (rst_i)
    state.ctrl[15:8] == 8'hC8 && !(fault_s && state.handling[0]) && !(climit_s && state.handling[1])
      |=> !(high_output_pin_o && low_output_pin_o))
    else $error("push-pull drove both pins");

  // Redundant mode puts the same level on both pins.
  chk_redundant_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    state.ctrl[15:8] == 8'hC4 && !(fault_s && state.handling[0]) && !(climit_s && state.handling[1])
      |=> high_output_pin_o == low_output_pin_o)
    else $error("redundant pair not equal");

  // With only the low pin inverted, a complementary pair shows equal levels.
  chk_low_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
    state.ctrl[15:8] == 8'hD0 && !(fault_s && state.handling[0]) && !(climit_s && state.handling[1])
      |=> high_output_pin_o == low_output_pin_o)
    else $error("low polarity not inverting");

endmodule

// [verif/ppc_power_stage_model.sv]
// ============================================================================
// Power stage model: the gate driver pair hanging on the two output pins.
// ============================================================================
module ppc_power_stage_model (
  input  wire logic high_gate_i,
  input  wire logic low_gate_i,
  output logic      high_on_o,
  output logic      low_on_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // The stage follows its gate inputs; its own delay is far below one clock,
  // so it is modelled as zero and the bench samples well after each edge.
  assign high_on_o = high_gate_i;
  assign low_on_o  = low_gate_i;
endmodule

// [verif/ppc_pin_control_tb_top.sv]
// ============================================================================
// Self-checking bench for the pin control stage.
// ============================================================================
module ppc_pin_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i, rst_i, wr_i, rd_i, lock_config_i, timebase_enable_i;
  logic        gen_high_i, gen_low_i, push_pull_phase_i, fault_i, current_limit_i;
  logic        gpio_high_i, gpio_low_i, high_output_pin_o, low_output_pin_o;
  logic        write_refused_o, stage_high, stage_low;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i, rdata_o, rd_val;
  int          err_count, comparisons, refused_seen, r0;

  ppc_pin_control u_ppc_pin_control (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .lock_config_i(lock_config_i), .timebase_enable_i(timebase_enable_i),
    .gen_high_i(gen_high_i), .gen_low_i(gen_low_i), .push_pull_phase_i(push_pull_phase_i),
    .fault_i(fault_i), .current_limit_i(current_limit_i), .gpio_high_i(gpio_high_i),
    .gpio_low_i(gpio_low_i), .high_output_pin_o(high_output_pin_o),
    .low_output_pin_o(low_output_pin_o), .write_refused_o(write_refused_o));

  ppc_power_stage_model u_ppc_power_stage_model (
    .high_gate_i(high_output_pin_o), .low_gate_i(low_output_pin_o),
    .high_on_o(stage_high), .low_on_o(stage_low));

  // ==========================================================================
  // Clock, refusal monitor and shared tasks.
  // ==========================================================================
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Counting pulses avoids guessing the exact cycle of the refusal flag.
  always @(posedge clk_i) begin
    if (write_refused_o === 1'b1) refused_seen++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe is taken.
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    rd_val = rdata_o;
    @(posedge clk_i);
  endtask

  // Both keys and the control word on consecutive cycles, strobe held high.
  task automatic unlock_wr(input logic [15:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= 4'h1;
    wdata_i <= ppc_pkg::UNLOCK_KEY_A;
    @(posedge clk_i);
    wdata_i <= ppc_pkg::UNLOCK_KEY_B;
    @(posedge clk_i);
    addr_i  <= 4'h0;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic pins(input int n, input logic h, input logic l);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    check("high pin", {15'h0000, stage_high}, {15'h0000, h});
    check("low pin", {15'h0000, stage_low}, {15'h0000, l});
    @(posedge clk_i);
  endtask

  task automatic end_of_test();
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_reset_values();
    rd(4'h0);
    check("ctrl reset", rd_val, 16'hC000);
    rd(4'hF);
    check("unmapped read", rd_val, 16'h0000);
  endtask

  task automatic t_gpio_owner();
    wr(4'h0, 16'h0003);
    rd(4'h0);
    check("ctrl low bits", rd_val, 16'h0000);
    gpio_high_i <= 1'b1;
    gpio_low_i  <= 1'b0;
    pins(5, 1'b1, 1'b0);
    gpio_high_i <= 1'b0;
    gpio_low_i  <= 1'b1;
    pins(5, 1'b0, 1'b1);
  endtask

  // Generator gives high 1, low 0; each mode but the reserved code, and each polarity, is visited.
  task automatic t_modes();
    logic [2:0] exp_l;
    exp_l = 3'b010;
    timebase_enable_i <= 1'b0;
    gen_high_i        <= 1'b1;
    gen_low_i         <= 1'b0;
    push_pull_phase_i <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        wr(4'h0, 16'hC000 | (p[0] ? 16'h3000 : 16'h0000) | (16'(m) << 10));
        pins(3, ~p[0], exp_l[m] ^ p[0]);
      end
    end
    push_pull_phase_i <= 1'b0;
    pins(3, 1'b1, 1'b0);
    wr(4'h0, 16'hC800);
    pins(3, 1'b0, 1'b1);
    wr(4'h0, 16'hE400);
    pins(3, 1'b0, 1'b1);
    wr(4'h0, 16'hD000);
    pins(3, 1'b1, 1'b1);
    timebase_enable_i <= 1'b1;
  endtask

  task automatic t_override();
    gen_high_i <= 1'b0;
    wr(4'h0, 16'hC380);
    pins(3, 1'b1, 1'b0);
  endtask

  // Override 11, fault data 10, limit data 01: each layer shows apart.
  task automatic t_fault_limit();
    wr(4'h3, 16'h0003);
    wr(4'h0, 16'hC3E4);
    fault_i         <= 1'b1;
    current_limit_i <= 1'b1;
    pins(5, 1'b1, 1'b0);
    fault_i <= 1'b0;
    pins(5, 1'b0, 1'b1);
    current_limit_i <= 1'b0;
    pins(5, 1'b1, 1'b1);
    wr(4'h0, 16'hF3E4);
    pins(3, 1'b0, 1'b0);
    fault_i <= 1'b1;
    wr(4'h3, 16'h0000);
    pins(5, 1'b0, 1'b0);
    fault_i <= 1'b0;
  endtask

  task automatic t_lock();
    lock_config_i <= 1'b1;
    r0 = refused_seen;
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge clk_i);
    rd(4'h0);
    check("locked write", rd_val, 16'hF3E4);
    check("refusal count", 16'(refused_seen), 16'(r0 + 1));
    wr(4'h1, 16'h0055);
    wr(4'h1, 16'h00AA);
    rd(4'h2);
    check("status unlocked", rd_val, 16'h0009);
    wr(4'h0, 16'hC000);
    rd(4'h0);
    check("unlocked write", rd_val, 16'hC000);
    wr(4'h0, 16'h4000);
    repeat (3) @(posedge clk_i);
    rd(4'h0);
    check("relocked write", rd_val, 16'hC000);
    check("refusal count", 16'(refused_seen), 16'(r0 + 2));
    unlock_wr(16'h4000);
    rd(4'h0);
    check("back to back unlock", rd_val, 16'h4000);
    lock_config_i <= 1'b0;
  endtask

  // A second reset in mid-run must bring back the reset configuration.
  task automatic t_reset_again();
    rst_i <= 1'b1;
    pins(2, 1'b0, 1'b0);
    rst_i <= 1'b0;
    rd(4'h0);
    check("ctrl after reset", rd_val, 16'hC000);
    pins(1, 1'b0, 1'b1);
  endtask

  // ==========================================================================
  // Main sequence and hang guard.
  // ==========================================================================
  initial begin
    {wr_i, rd_i, lock_config_i, timebase_enable_i, gen_high_i, gen_low_i} = '0;
    {push_pull_phase_i, fault_i, current_limit_i, gpio_high_i, gpio_low_i} = '0;
    addr_i       = 4'h0;
    wdata_i      = 16'h0000;
    err_count    = 0;
    comparisons  = 0;
    refused_seen = 0;
    rst_i        = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_gpio_owner();
    t_modes();
    t_override();
    t_fault_limit();
    t_lock();
    t_reset_again();
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end
endmodule
